// ==== rtl/rcfg_pkg.sv ====
// package of register offsets, fields and reset values for the config bank
package rcfg_pkg;
  // register addresses on the transceiver register port
  localparam logic [4:0] ADDR_CONFIG   = 5'h00;
  localparam logic [4:0] ADDR_AUTO_ACK = 5'h01;
  localparam logic [4:0] ADDR_RX_PIPES = 5'h02;
  localparam logic [4:0] ADDR_TEST_LO  = 5'h18;
  localparam logic [4:0] ADDR_TEST_HI  = 5'h1b;
  // configuration field positions
  localparam int BIT_MASK_RX  = 6;
  localparam int BIT_MASK_TX  = 5;
  localparam int BIT_MASK_RT  = 4;
  localparam int BIT_CRC_EN   = 3;
  localparam int BIT_CRC_LEN  = 2;
  localparam int BIT_POWER_UP_CONTROL   = 1;
  localparam int BIT_PRIMARY_RECEIVER_SELECT  = 0;
  localparam int NUM_PIPES    = 6;
  // writable masks; cleared bits are reserved and read as zero
  localparam logic [7:0] CONFIG_WMASK = 8'h7f;
  localparam logic [7:0] PIPE_WMASK   = 8'h3f;
  // reset values
  localparam logic [7:0] CONFIG_RST   = 8'h08;
  localparam logic [7:0] AUTO_ACK_RST = 8'h3f;
  localparam logic [7:0] RX_PIPES_RST = 8'h03;
endpackage

// ==== rtl/rcfg_irq.sv ====
// interrupt combiner: sticky flags gated by mask bits onto the active-low line
`timescale 1ns/10ps
`default_nettype none
module rcfg_irq (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [2:0] flags,      // rx ready, tx sent, retry limit
  input  wire logic [2:0] masks,      // same order; 1 keeps flag off line
  output logic            irq_n_reg   // registered active-low interrupt
);
  typedef struct packed {
    logic irq_n;
  } rcfg_irq_st_t;
  rcfg_irq_st_t st_reg;
  rcfg_irq_st_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // line low while any unmasked flag stands
  always_comb begin
    st_next = st_reg;
    st_next.irq_n = ~|(flags & ~masks);
  end

  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg.irq_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_n_reg = st_reg.irq_n;

  // line is low one cycle after any unmasked flag, high otherwise
  chk_irq_follows: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> irq_n_reg == ~|($past(flags) & ~$past(masks)))
    else $error("interrupt line does not follow unmasked flags");
endmodule
`default_nettype wire

// ==== rtl/rcfg_regs.sv ====
// configuration register bank of the radio core: config, auto-ack, rx pipes
`timescale 1ns/10ps
`default_nettype none
module rcfg_regs (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       reg_wr,            // one-cycle write command
  input  wire logic       reg_rd,            // one-cycle read command
  input  wire logic [4:0] reg_addr,          // register address
  input  wire logic [7:0] reg_wdata,         // write data
  input  wire logic       receive_ready_flag,  // status flags, same clock
  input  wire logic       transmit_sent_flag,
  input  wire logic       retry_limit_flag,
  output logic [7:0]      reg_rdata,         // registered read data
  output logic            reg_rvalid,        // read data valid pulse
  output logic            radio_interrupt_out, // active low
  output logic            crc_enable,        // effective crc enable
  output logic            checksum_length_select,
  output logic            power_up_control,
  output logic            primary_receiver_select,
  output logic [5:0]      auto_ack_enables,
  output logic [5:0]      receive_pipe_enables,
  output logic            test_write_seen    // sticky: test range was hit
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] aa;
    logic [7:0] rxp;
    logic [7:0] rdata;
    logic       rvalid;
    logic       test_hit;
    logic       crc_eff;
  } rcfg_st_t;
  rcfg_st_t st_reg;
  rcfg_st_t st_next;

  // readback with crc enable forced and reserved bits zeroed
  function automatic logic [7:0] rd_mux(input logic [4:0] a,
                                        input rcfg_st_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      rcfg_pkg::ADDR_CONFIG: begin
        v = s.cfg & rcfg_pkg::CONFIG_WMASK;
        if (|s.aa[5:0]) begin
          v[rcfg_pkg::BIT_CRC_EN] = 1'b1;
        end
      end
      rcfg_pkg::ADDR_AUTO_ACK: v = s.aa & rcfg_pkg::PIPE_WMASK;
      rcfg_pkg::ADDR_RX_PIPES: v = s.rxp & rcfg_pkg::PIPE_WMASK;
      default: v = 8'h00; // unmapped reads zero
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state: writes, reads and derived outputs
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    if (reg_wr) begin
      // reserved bits are dropped so they stay zero
      unique case (reg_addr)
        rcfg_pkg::ADDR_CONFIG:
          st_next.cfg = reg_wdata & rcfg_pkg::CONFIG_WMASK;
        rcfg_pkg::ADDR_AUTO_ACK:
          st_next.aa = reg_wdata & rcfg_pkg::PIPE_WMASK;
        rcfg_pkg::ADDR_RX_PIPES:
          st_next.rxp = reg_wdata & rcfg_pkg::PIPE_WMASK;
        default: begin
          // test range is not implemented here; flag the misuse
          if (reg_addr >= rcfg_pkg::ADDR_TEST_LO &&
              reg_addr <= rcfg_pkg::ADDR_TEST_HI) begin
            st_next.test_hit = 1'b1;
          end
        end
      endcase
    end
    if (reg_rd) begin
      st_next.rdata  = rd_mux(reg_addr, st_reg);
      st_next.rvalid = 1'b1;
    end
    // effective crc enable from the registers as they will stand
    st_next.crc_eff = st_next.cfg[rcfg_pkg::BIT_CRC_EN] |
                      (|st_next.aa[5:0]);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register with reset values
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg.cfg      <= rcfg_pkg::CONFIG_RST;
      st_reg.aa       <= rcfg_pkg::AUTO_ACK_RST;
      st_reg.rxp      <= rcfg_pkg::RX_PIPES_RST;
      st_reg.rdata    <= 8'h00;
      st_reg.rvalid   <= 1'b0;
      st_reg.test_hit <= 1'b0;
      st_reg.crc_eff  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt combiner, masks from configuration
  rcfg_irq u_irq (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .flags     ({receive_ready_flag, transmit_sent_flag, retry_limit_flag}),
    .masks     ({st_reg.cfg[rcfg_pkg::BIT_MASK_RX],
                 st_reg.cfg[rcfg_pkg::BIT_MASK_TX],
                 st_reg.cfg[rcfg_pkg::BIT_MASK_RT]}),
    .irq_n_reg (radio_interrupt_out)
  );

  // outputs straight from flops; power and role bits
  assign reg_rdata               = st_reg.rdata;
  assign reg_rvalid              = st_reg.rvalid;
  assign crc_enable              = st_reg.crc_eff;
  assign checksum_length_select  = st_reg.cfg[rcfg_pkg::BIT_CRC_LEN];
  assign power_up_control        = st_reg.cfg[rcfg_pkg::BIT_POWER_UP_CONTROL];
  assign primary_receiver_select = st_reg.cfg[rcfg_pkg::BIT_PRIMARY_RECEIVER_SELECT];
  assign auto_ack_enables        = st_reg.aa[5:0];
  assign receive_pipe_enables    = st_reg.rxp[5:0];
  assign test_write_seen         = st_reg.test_hit;

  ////////////////////////////////////////////////////////////////////////
  // checks on the register port and the derived outputs; all of them
  // wait for reset release, and the first attempt after it starts from reset values

  // bit 7 is reserved in all three registers and reads as zero
  chk_rd_top_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_rvalid |-> !reg_rdata[7])
    else $error("reserved read bit 7 not zero");
  // pipe registers also keep bits 7:6 clear; config bit 6 is a mask
  chk_rd_resv_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_rd && (reg_addr == rcfg_pkg::ADDR_AUTO_ACK ||
                reg_addr == rcfg_pkg::ADDR_RX_PIPES)) |=>
    (reg_rdata[7:6] == 2'b00))
    else $error("reserved pipe read bits not zero");
  // unmapped addresses, the test range included, read as zero
  chk_rd_unmapped: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_rd && reg_addr > rcfg_pkg::ADDR_RX_PIPES) |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");
  // valid pulse exactly one cycle after each read command
  chk_rvalid_pulse: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> (reg_rvalid == $past(reg_rd)))
    else $error("read valid not one cycle after read");
  // read data holds between reads
  chk_rdata_hold: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  // crc enable acts as set while any auto-ack bit is set
  chk_crc_forced: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (|auto_ack_enables) |-> crc_enable)
    else $error("crc not forced with auto-ack");
  // crc enable bit reads as set while any auto-ack bit is set
  chk_cfg_readback: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_rd && reg_addr == rcfg_pkg::ADDR_CONFIG) |=> reg_rvalid &&
    (reg_rdata[rcfg_pkg::BIT_CRC_EN] ==
     ($past(st_reg.cfg[rcfg_pkg::BIT_CRC_EN]) | (|$past(st_reg.aa[5:0])))))
    else $error("config readback crc bit wrong");
  // config write lands on power and role outputs
  chk_cfg_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && reg_addr == rcfg_pkg::ADDR_CONFIG) |=>
    (power_up_control == $past(reg_wdata[rcfg_pkg::BIT_POWER_UP_CONTROL]) &&
     primary_receiver_select == $past(reg_wdata[rcfg_pkg::BIT_PRIMARY_RECEIVER_SELECT])))
    else $error("config write not applied");
  // config write lands on the checksum length output
  chk_crc_len_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && reg_addr == rcfg_pkg::ADDR_CONFIG) |=>
    (checksum_length_select == $past(reg_wdata[rcfg_pkg::BIT_CRC_LEN])))
    else $error("crc length write not applied");
  // pipe enable writes land one cycle later
  chk_aa_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && reg_addr == rcfg_pkg::ADDR_AUTO_ACK) |=>
    (auto_ack_enables == $past(reg_wdata[5:0])))
    else $error("auto-ack write not applied");
  chk_rxp_write: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && reg_addr == rcfg_pkg::ADDR_RX_PIPES) |=>
    (receive_pipe_enables == $past(reg_wdata[5:0])))
    else $error("rx pipe write not applied");
  // a write into the test range is remembered until reset
  chk_test_set: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (reg_wr && reg_addr >= rcfg_pkg::ADDR_TEST_LO &&
     reg_addr <= rcfg_pkg::ADDR_TEST_HI) |=> test_write_seen)
    else $error("test range write not flagged");
  chk_test_sticky: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    test_write_seen |=> test_write_seen)
    else $error("test range flag dropped");
  // each unmasked source pulls the line low one cycle later
  chk_irq_rx_mask: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (receive_ready_flag && !st_reg.cfg[rcfg_pkg::BIT_MASK_RX]) |=>
    !radio_interrupt_out)
    else $error("unmasked rx ready did not pull line low");
  chk_irq_tx_mask: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (transmit_sent_flag && !st_reg.cfg[rcfg_pkg::BIT_MASK_TX]) |=>
    !radio_interrupt_out)
    else $error("unmasked tx sent did not pull line low");
  chk_irq_rt_mask: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (retry_limit_flag && !st_reg.cfg[rcfg_pkg::BIT_MASK_RT]) |=>
    !radio_interrupt_out)
    else $error("unmasked retry limit did not pull line low");
  // with no flag standing the line is released
  chk_irq_release: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (!receive_ready_flag && !transmit_sent_flag && !retry_limit_flag)
    |=> radio_interrupt_out)
    else $error("line low without any flag");
endmodule
`default_nettype wire

// ==== verification/rcfg_status_model.sv ====
// status flag model: events set sticky flags, controller clears by one
`timescale 1ns/10ps
`default_nettype none
module rcfg_status_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [2:0] event_set,  // rx ready, tx sent, retry limit
  input  wire logic [2:0] clear_one,  // controller writes one to clear
  output logic [2:0]      flags_reg   // sticky status flags
);
  // set wins over clear so an event arriving with a clear is not lost
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) flags_reg <= 3'h0;
    else flags_reg <= (flags_reg & ~clear_one) | event_set;
  end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench of the radio configuration register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, (a), (b)); \
  end \
end
module testbench;
  logic       clk_sys, nrst, reg_wr, reg_rd;   // clock, reset, commands
  logic [4:0] reg_addr;                        // register address
  logic [7:0] reg_wdata, reg_rdata;            // write and read data
  logic       reg_rvalid, radio_interrupt_out; // read pulse, irq line
  logic       crc_enable, checksum_length_select, power_up_control;
  logic       primary_receiver_select, test_write_seen;
  logic [5:0] auto_ack_enables, receive_pipe_enables;
  logic [2:0] ev, clr, flags;                  // model stimulus, flags
  int         n_mismatch, comparisons, cycles;
  rcfg_regs uut (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .receive_ready_flag(flags[0]), .transmit_sent_flag(flags[1]),
    .retry_limit_flag(flags[2]), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .radio_interrupt_out(radio_interrupt_out),
    .crc_enable(crc_enable), .checksum_length_select(checksum_length_select),
    .power_up_control(power_up_control),
    .primary_receiver_select(primary_receiver_select),
    .auto_ack_enables(auto_ack_enables),
    .receive_pipe_enables(receive_pipe_enables),
    .test_write_seen(test_write_seen));
  rcfg_status_model model (.clk_sys(clk_sys), .nrst(nrst), .event_set(ev),
    .clear_one(clr), .flags_reg(flags));
  ////////////////////////////////////////////////////////////////////////
  // clock and a cycle ceiling well above the fewer than a hundred cycles needed
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // write: one-cycle command, outputs settle after the taking edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
    end
    @(posedge clk_sys) reg_wr <= 1'b0;
    #1;
  endtask
  // read: data valid for one cycle after the taking edge
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys) begin
      reg_rd   <= 1'b1;
      reg_addr <= a;
    end
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 `CHK({reg_rvalid, reg_rdata}, {1'b1, e})
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values, unmapped reads return zero
  task automatic t_reset();
    rd(5'h00, 8'h08);
    rd(5'h01, 8'h3f);
    rd(5'h02, 8'h03);
    rd(5'h05, 8'h00);
    `CHK({radio_interrupt_out, power_up_control}, 2'h2)
    `CHK(test_write_seen, 1'b0)
    $display("reset test done");
  endtask
  // role, power, crc forcing and reserved bits
  task automatic t_fields();
    wr(5'h00, 8'h03);
    `CHK({power_up_control, primary_receiver_select}, 2'h3)
    rd(5'h00, 8'h0b);
    wr(5'h01, 8'hff);
    rd(5'h01, 8'h3f);
    wr(5'h01, 8'h00);
    wr(5'h00, 8'hf4);
    `CHK({crc_enable, checksum_length_select}, 2'h1)
    rd(5'h00, 8'h74);
    wr(5'h01, 8'h20);
    `CHK({crc_enable, auto_ack_enables}, 7'h60)
    wr(5'h02, 8'hfc);
    `CHK(receive_pipe_enables, 6'h3c)
    rd(5'h02, 8'h3c);
    $display("field test done");
  endtask
  // one event source with a given mask; line follows flag by one cycle
  task automatic irq_case(input int i, input logic m, input logic e);
    wr(5'h00, m ? (8'h40 >> i) : 8'h00); // reserved bit 7 zero
    @(posedge clk_sys) ev <= 3'(3'h1 << i);
    @(posedge clk_sys) ev <= 3'h0;
    @(posedge clk_sys) #1 `CHK(radio_interrupt_out, e)
    @(posedge clk_sys) clr <= 3'(3'h1 << i);
    @(posedge clk_sys) clr <= 3'h0;
    @(posedge clk_sys) #1 `CHK(radio_interrupt_out, 1'b1)
  endtask
  // every source masked and unmasked in turn
  task automatic t_irq();
    irq_case(0, 1'b0, 1'b0);
    irq_case(0, 1'b1, 1'b1);
    irq_case(1, 1'b0, 1'b0);
    irq_case(1, 1'b1, 1'b1);
    irq_case(2, 1'b0, 1'b0);
    irq_case(2, 1'b1, 1'b1);
    $display("interrupt test done");
  endtask
  // a write into the test range is dropped but remembered
  task automatic t_test_range();
    wr(5'h18, 8'h00);
    wr(5'h1b, 8'h00);
    `CHK(test_write_seen, 1'b1)
    rd(5'h18, 8'h00);
    $display("test range test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict, printed once from here only
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, ev, clr} = '0;
    {n_mismatch, comparisons, cycles} = '0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_fields();
    t_irq();
    t_test_range();
    test_done();
  end
endmodule
`default_nettype wire
